// >>> hw/pmr_top.sv
// Power-mode and reset controller: nap, doze and deep-halt modes plus the reset sequencer.
// Assumes the core writes registers at the end of an instruction and that inputs are synchronous to clk.
module pmr_top
    import pmr_pkg::*;
#(
    parameter int unsigned POR_CYC = POR_DELAY_CYC
)
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire pmr_bus_t   bus,
    output logic [7:0]      rdata,
    input  wire logic       supply_ok,
    input  wire logic       other_rst_req,
    input  wire logic       mcd_timeout,
    input  wire logic       irq_pending,
    input  wire logic       timer3_ext_clk,
    input  wire pmr_wake_t  wake,
    output pmr_ctrl_t       ctrl,
    output logic            rst_pin_o,
    output logic            rst_pin_oe_n
);

    typedef struct packed {
        pmr_state_t       state;
        pmr_cause_t       cause;
        logic             por_wait;
        logic [CNT_W-1:0] cnt;
        logic [5:0]       gpf;
        logic [2:0]       clkdiv;
        logic             mon_en;
        logic             mon_sel;
        logic             power_up_cause_flag;
        logic             mcd_en;
        logic             mcd_flag;
        logic             boot;
        logic [7:0]       rdata;
    } pmr_regs_t;

    localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_START_CYC - 1);

    pmr_regs_t q;
    pmr_regs_t next_q;

    logic rst_mon;
    logic rst_mcd;
    logic any_rst;
    logic doze_wake;
    logic wr_power_mode_control;
    logic wr_osc;

    function automatic logic hit(input pmr_bus_t b, input logic [7:0] a);
        hit = b.wr && (b.addr == a);
    endfunction

    // The wake term is plain combinational logic of the inputs, so it needs no running oscillator.
    always_comb
    begin
        rst_mon   = q.mon_en && q.mon_sel && !supply_ok;  // R21
        rst_mcd   = q.mcd_en && mcd_timeout;  // R04
        any_rst   = rst_mon || rst_mcd || other_rst_req;
        // Pulsed sources are only seen while dozing, so events that fired earlier are lost by design.
        doze_wake = wake.port_match || wake.timer2_ovf || (wake.cmp_wake_en && wake.cmp_low)
                    || wake.cs_gt;  // R08 R10 R25
        wr_power_mode_control   = hit(bus, ADDR_POWER_MODE);
        wr_osc    = hit(bus, ADDR_OSC_CTRL) && bus.wdata[BIT_DOZE];
    end

    always_comb
    begin
        next_q       = q;
        next_q.boot  = 1'b0;
        next_q.rdata = 8'h00;
        if (any_rst)
        begin
            // A power-on wait that is interrupted keeps its cause but restarts its delay.
            if (!(q.state == ST_RESET && q.por_wait))
            begin
                next_q.por_wait = 1'b0;
                if (rst_mon)
                begin
                    next_q.cause = CAUSE_SUPPLY;
                end
                else if (rst_mcd)
                begin
                    next_q.cause = CAUSE_MCD;
                end
                else
                begin
                    next_q.cause = CAUSE_OTHER;
                end
            end
            next_q.state  = ST_RESET;  // R03 R13 R23
            next_q.cnt    = '0;
            next_q.gpf    = GPF_RESET;  // R13
            next_q.clkdiv = CLKDIV_RESET;
            next_q.mcd_en = 1'b0;
        end
        else
        begin
            unique case (q.state)
                ST_RESET:
                begin
                    if (!q.por_wait || (supply_ok && q.cnt == POR_LAST))  // R18 R21
                    begin
                        next_q.state    = ST_RUN;
                        next_q.por_wait = 1'b0;
                        next_q.boot     = 1'b1;  // R17
                        next_q.power_up_cause_flag    = (q.cause == CAUSE_POR);  // R19
                        next_q.mcd_flag = (q.cause == CAUSE_MCD);  // R24
                        next_q.cnt      = '0;
                    end
                    else if (supply_ok)
                    begin
                        next_q.cnt = q.cnt + CNT_W'(1);  // R18
                    end
                    else
                    begin
                        next_q.cnt = '0;
                    end
                end
                ST_RUN:
                begin
                    if (wr_power_mode_control && bus.wdata[BIT_HALT])
                    begin
                        next_q.state = ST_HALT;  // R01
                    end
                    else if (wr_power_mode_control && bus.wdata[BIT_NAP])
                    begin
                        next_q.state = ST_NAP;  // R11
                    end
                    else if (wr_osc)
                    begin
                        // The divider is not checked here; keeping it at one is up to software.
                        next_q.state = ST_DOZE;  // R05 R07 R10
                    end
                end
                ST_NAP:
                begin
                    if (irq_pending)
                    begin
                        next_q.state = ST_RUN;  // R23
                    end
                end
                ST_DOZE:
                begin
                    if (doze_wake)
                    begin
                        next_q.state = ST_WAKE;  // R08 R25
                        next_q.cnt   = '0;
                    end
                end
                ST_WAKE:
                begin
                    if (q.cnt >= OSC_LAST)
                    begin
                        next_q.state = ST_RUN;  // R09 R25
                        next_q.cnt   = '0;
                    end
                    else
                    begin
                        next_q.cnt = q.cnt + CNT_W'(1);
                    end
                end
                ST_HALT:
                begin
                    next_q.state = ST_HALT;  // R03
                end
                default:
                begin
                    next_q.state = ST_RESET;
                end
            endcase

            if (q.state != ST_RESET && bus.wr)
            begin
                unique case (bus.addr)
                    ADDR_POWER_MODE:
                    begin
                        next_q.gpf = bus.wdata[7:2];  // R12
                    end
                    ADDR_CLK_SEL:
                    begin
                        next_q.clkdiv = bus.wdata[2:0];
                    end
                    ADDR_RST_SRC:
                    begin
                        next_q.mon_sel = bus.wdata[BIT_POWER_UP_CAUSE_FLAG];  // R22
                        next_q.mcd_en  = bus.wdata[BIT_MCD];  // R24
                    end
                    ADDR_MON_CTRL:
                    begin
                        next_q.mon_en = bus.wdata[BIT_MON_EN];
                    end
                    default:
                    begin
                    end
                endcase
            end

            if (q.state != ST_RESET && bus.rd)
            begin
                unique case (bus.addr)
                    ADDR_POWER_MODE:
                    begin
                        next_q.rdata = {q.gpf, 2'b00};  // R11 R12
                    end
                    ADDR_CLK_SEL:
                    begin
                        next_q.rdata = {5'h00, q.clkdiv};
                    end
                    ADDR_RST_SRC:
                    begin
                        next_q.rdata = {5'h00, q.mcd_flag, q.power_up_cause_flag, 1'b0};  // R19 R24
                    end
                    ADDR_MON_CTRL:
                    begin
                        next_q.rdata = {q.mon_en, supply_ok, 6'h00};
                    end
                    default:
                    begin
                        next_q.rdata = 8'h00;
                    end
                endcase
            end
        end
    end

    // Only control state is here; data memory lives elsewhere and never sees this reset.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q          <= '0;
            q.state    <= ST_RESET;
            q.cause    <= CAUSE_POR;
            q.por_wait <= 1'b1;  // R18
            q.gpf      <= GPF_RESET;
            q.clkdiv   <= CLKDIV_RESET;
            q.mon_en   <= 1'b1;  // R20
            q.mon_sel  <= 1'b1;  // R20
        end
        else
        begin
            q <= next_q;  // R14
        end
    end

    always_comb
    begin
        rdata               = q.rdata;
        ctrl.core_rst       = (q.state == ST_RESET);  // R13
        ctrl.cpu_clk_en     = (q.state == ST_RUN);  // R11 R23
        ctrl.int_osc_en     = !(q.state == ST_HALT || q.state == ST_DOZE);  // R02 R05
        ctrl.periph_clk_en  = (q.state == ST_RUN || q.state == ST_NAP);  // R02 R06 R11
        ctrl.port_match_en  = (q.state != ST_RESET && q.state != ST_HALT);  // R06
        ctrl.timer3_en      = ctrl.periph_clk_en || (q.state == ST_DOZE && timer3_ext_clk);  // R06
        ctrl.port_force     = (q.state == ST_RESET);  // R15
        ctrl.weak_pullup_en = 1'b1;  // R15
        ctrl.boot           = q.boot;  // R17
        ctrl.clk_div        = q.clkdiv;
        rst_pin_o           = 1'b0;
        rst_pin_oe_n        = !(q.state == ST_RESET
                                && (q.cause == CAUSE_POR || q.cause == CAUSE_SUPPLY));  // R16
    end

endmodule

// >>> hw/pmr_pkg.sv
// Constants, register map and carrier types of the power-mode and reset controller.
// Assumes an 8-bit register port driven by the processor core and a 100 MHz system clock.
// Notes on behaviour
// (R01) Writing the deep-halt select bit enters deep-halt after the writing instruction completes.
// (R02) Deep-halt stops internal oscillator, CPU and digital peripherals; external oscillator is untouched.
// (R03) Only a reset ends deep-halt; execution then restarts at address zero.
// (R04) An enabled missing-clock detector resets the device and ends deep-halt.
// (R05) Setting the doze bit halts CPU and internal oscillator; all state is kept.
// (R06) In doze, peripherals sleep; port match stays on, third timer runs only on external clock.
// (R07) Software sets the clock divider to divide-by-one before entering doze.
// (R08) Doze ends on port match, second-timer overflow, comparator low, capacitive greater-than, or reset.
// (R09) A non-reset wake resumes after the doze write, interrupt serviced first.
// (R10) Events pending before doze entry do not wake; a held port match still does.
// (R11) Deep-halt and nap bits read zero; nap stops only the CPU clock.
// (R12) Power control bits 7 to 2 are plain read/write flags resetting to zero.
// (R13) Reset stops execution, reloads registers, forces ports, disables interrupts and timers.
// (R14) Reset keeps data memory; only the stack pointer is reset.
// (R15) Reset loads port latches with ones, open-drain, weak pull-ups enabled.
// (R16) Power-on and supply-monitor resets drive the reset pin low while in reset.
// (R17) Reset exit clears the PC, picks internal oscillator, enables watchdog at clock/12.
// (R18) After power-up the release waits a delay once supply exceeds the threshold.
// (R19) Power-on exit sets the power-up cause flag; other resets clear it.
// (R20) Power-on enables and selects the supply monitor; other resets leave it alone.
// (R21) Supply below threshold holds reset; release above threshold without power-on delay.
// (R22) Software enables the monitor, waits, then selects it by writing the cause bit.
// (R23) An enabled interrupt ends nap, clearing the nap bit; reset also ends nap.
// (R24) Writing the missing-clock flag bit enables or disables the detector; it reads one after its reset.
// (R25) Wake inputs are watched without the internal oscillator; it restarts before the CPU resumes.
package pmr_pkg;

    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned POR_DELAY_MS     = 10;
    localparam int unsigned POR_DELAY_CYC    = POR_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned OSC_START_NS     = 50;
    localparam int unsigned OSC_START_CYC    = (OSC_START_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W            = 24;

    localparam logic [7:0] ADDR_POWER_MODE   = 8'h87;
    localparam logic [7:0] ADDR_OSC_CTRL     = 8'hb2;
    localparam logic [7:0] ADDR_CLK_SEL      = 8'ha9;
    localparam logic [7:0] ADDR_RST_SRC      = 8'hef;
    localparam logic [7:0] ADDR_MON_CTRL     = 8'hff;

    localparam int unsigned BIT_NAP          = 0;
    localparam int unsigned BIT_HALT         = 1;
    localparam int unsigned BIT_DOZE         = 5;
    localparam int unsigned BIT_POWER_UP_CAUSE_FLAG        = 1;
    localparam int unsigned BIT_MCD          = 2;
    localparam int unsigned BIT_MON_EN       = 7;
    localparam int unsigned BIT_MON_STAT     = 6;

    localparam logic [5:0] GPF_RESET         = 6'h00;
    localparam logic [2:0] CLKDIV_RESET      = 3'h3;
    localparam logic [2:0] CLKDIV_ONE        = 3'h0;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RUN   = 3'b001,
        ST_NAP   = 3'b011,
        ST_DOZE  = 3'b010,
        ST_WAKE  = 3'b110,
        ST_HALT  = 3'b111
    } pmr_state_t;

    typedef enum logic [1:0] {
        CAUSE_POR    = 2'h0,
        CAUSE_SUPPLY = 2'h1,
        CAUSE_OTHER  = 2'h2,
        CAUSE_MCD    = 2'h3
    } pmr_cause_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pmr_bus_t;

    typedef struct packed {
        logic port_match;
        logic timer2_ovf;
        logic cmp_low;
        logic cmp_wake_en;
        logic cs_gt;
    } pmr_wake_t;

    typedef struct packed {
        logic       core_rst;
        logic       cpu_clk_en;
        logic       int_osc_en;
        logic       periph_clk_en;
        logic       port_match_en;
        logic       timer3_en;
        logic       port_force;
        logic       weak_pullup_en;
        logic       boot;
        logic [2:0] clk_div;
    } pmr_ctrl_t;

endpackage

// >>> test/pmr_properties.sv
// Checker of the power-mode and reset controller, seeing only the top ports.
// Assumes it is bound to pmr_top and that the core writes only while running.
module pmr_properties
    import pmr_pkg::*;
#(
    parameter int unsigned POR_CYC = 8
)
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire pmr_bus_t   bus,
    input wire logic [7:0] rdata,
    input wire logic       supply_ok,
    input wire logic       other_rst_req,
    input wire logic       mcd_timeout,
    input wire logic       irq_pending,
    input wire logic       timer3_ext_clk,
    input wire pmr_wake_t  wake,
    input wire pmr_ctrl_t  ctrl,
    input wire logic       rst_pin_o,
    input wire logic       rst_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Modes are read back from the enables, so a wrong decode shows up too.
    wire quiet = supply_ok && !other_rst_req && !mcd_timeout;
    wire run   = ctrl.cpu_clk_en && !ctrl.core_rst;
    wire nap   = ctrl.periph_clk_en && !ctrl.cpu_clk_en && !ctrl.core_rst;
    wire doze  = !ctrl.int_osc_en && ctrl.port_match_en;
    wire halt  = !ctrl.int_osc_en && !ctrl.port_match_en && !ctrl.core_rst;
    wire wk    = wake.port_match || wake.timer2_ovf || (wake.cmp_low && wake.cmp_wake_en) || wake.cs_gt;
    wire pw    = bus.wr && bus.addr == ADDR_POWER_MODE;
    wire dw    = bus.wr && bus.addr == ADDR_OSC_CTRL && bus.wdata[BIT_DOZE];

    a_halt_entry: assert property (run && pw && bus.wdata[BIT_HALT] && quiet |=> halt)
        else $error("deep halt not entered");
    a_halt_hold: assert property (halt && quiet |=> halt)
        else $error("deep halt left without reset");
    a_halt_reset: assert property (halt && other_rst_req |=> ctrl.core_rst)
        else $error("reset did not end deep halt");
    a_nap_entry: assert property (run && pw && bus.wdata[1:0] == 2'h1 && quiet |=> nap)
        else $error("nap not entered");
    a_nap_exit: assert property (nap && irq_pending && quiet |=> run)
        else $error("interrupt did not end nap");
    a_doze_entry: assert property (run && dw && quiet |=> doze && !ctrl.periph_clk_en)
        else $error("doze not entered");
    a_doze_hold: assert property (doze && !wk && quiet |=> doze)
        else $error("doze left without wake event");
    a_doze_timer: assert property (doze |-> ctrl.timer3_en == timer3_ext_clk)
        else $error("third timer enable wrong in doze");
    a_doze_wake: assert property (doze && wk && quiet |=> (ctrl.int_osc_en && !ctrl.cpu_clk_en)[*5] ##1 run)
        else $error("doze wake sequence wrong");
    a_mode_read: assert property (run && bus.rd && bus.addr == ADDR_POWER_MODE |=> rdata[1:0] == 2'h0)
        else $error("mode bits read nonzero");
    a_pin_drive: assert property (!rst_pin_oe_n |-> ctrl.core_rst && !rst_pin_o)
        else $error("reset pin driven outside reset");
    a_supply_hold: assert property (!supply_ok |=> ctrl.core_rst && !rst_pin_oe_n)
        else $error("low supply did not hold reset");
    a_boot_exit: assert property ($fell(ctrl.core_rst) |-> ctrl.boot)
        else $error("no boot pulse on reset exit");
    a_reset_ports: assert property (ctrl.core_rst |-> ctrl.port_force && ctrl.weak_pullup_en && !ctrl.cpu_clk_en)
        else $error("ports not forced in reset");

    c_doze_wake: cover property (doze && wk);
    c_nap_exit: cover property (nap && irq_pending);
    c_halt_mcd: cover property (halt && mcd_timeout);
endmodule

bind pmr_top pmr_properties #(.POR_CYC(POR_CYC)) u_pmr_properties (.clk, .sys_rst, .bus, .rdata, .supply_ok,
    .other_rst_req, .mcd_timeout, .irq_pending, .timer3_ext_clk, .wake, .ctrl, .rst_pin_o, .rst_pin_oe_n);

// >>> test/pmr_partner.sv
// Model of the wake sources and reset sources facing the controller.
// Assumes the bench calls fire from its main sequence; levels idle low, supply idles good.
module pmr_partner
    import pmr_pkg::*;
(
    input  wire logic clk,
    output pmr_wake_t wake,
    output logic      supply_ok,
    output logic      other_rst_req,
    output logic      mcd_timeout,
    output logic      irq_pending
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        wake = '0;
        supply_ok = 1'b1;
        other_rst_req = 1'b0;
        mcd_timeout = 1'b0;
        irq_pending = 1'b0;
    end

    // Bits: 8 supply low, 7 other reset, 6 clock lost, 5 interrupt, 4:0 wake.
    // A large d gives a slow answer; every source drops back once n cycles pass.
    task automatic fire(input int d, input int n, input logic [8:0] v);
        repeat (d) @(posedge clk);
        supply_ok <= !v[8];
        other_rst_req <= v[7];
        mcd_timeout <= v[6];
        irq_pending <= v[5];
        wake <= v[4:0];
        repeat (n) @(posedge clk);
        supply_ok <= 1'b1;
        other_rst_req <= 1'b0;
        mcd_timeout <= 1'b0;
        irq_pending <= 1'b0;
        wake <= '0;
    endtask
endmodule

// >>> test/tb.sv
// Self-checking bench of the power-mode and reset controller against a register model.
// Assumes pmr_top with a short power-on delay, the partner model and the bound checker.
module tb
    import pmr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned POR = 8;
    logic       clk;
    logic       sys_rst;
    pmr_bus_t   bus;
    logic [7:0] rdata;
    logic       supply_ok;
    logic       other_rst_req;
    logic       mcd_timeout;
    logic       irq_pending;
    logic       timer3_ext_clk;
    pmr_wake_t  wake;
    pmr_ctrl_t  ctrl;
    logic       rst_pin_o;
    logic       rst_pin_oe_n;
    logic [7:0] mdl [256];
    logic [4:0] wk [4] = '{5'h10, 5'h08, 5'h06, 5'h01};
    logic [7:0] v;
    int         errors;
    int         checked;
    int         n;
    int         seed;

    pmr_top #(.POR_CYC(POR)) u_pmr_top (.clk, .sys_rst, .bus, .rdata, .supply_ok, .other_rst_req,
        .mcd_timeout, .irq_pending, .timer3_ext_clk, .wake, .ctrl, .rst_pin_o, .rst_pin_oe_n);
    pmr_partner u_pmr_partner (.clk, .wake, .supply_ok, .other_rst_req, .mcd_timeout, .irq_pending);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        if (a == ADDR_POWER_MODE)
            mdl[a] = d & 8'hfc;
        if (a == ADDR_MON_CTRL)
            mdl[a] = {d[7], 7'h40};
    endtask

    task automatic rd(input logic [7:0] a, input string what);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk(rdata, mdl[a], what);
    endtask

    task automatic wait_run(output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (ctrl.cpu_clk_en !== 1'b1 && k < 50);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #100000;
        errors++;
        give_verdict;
    end

    initial
    begin
        seed = 32'h9f129cb1;
        sys_rst = 1'b1;
        bus = '0;
        timer3_ext_clk = 1'b0;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[ADDR_RST_SRC] = 8'h02;
        mdl[ADDR_MON_CTRL] = 8'hc0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(8'({ctrl.core_rst, ctrl.port_force, ctrl.weak_pullup_en, rst_pin_oe_n}), 8'h0e, "reset pins");
        chk(8'(ctrl.clk_div), 8'(CLKDIV_RESET), "divider reset");
        @(posedge clk);
        sys_rst <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (ctrl.core_rst === 1'b1 && n < 40);
        chk(8'(n), 8'(POR + 1), "release delay");
        chk(8'(ctrl.boot), 8'h01, "boot pulse");
        $display("test reset done");
        rd(ADDR_POWER_MODE, "power mode");
        rd(ADDR_RST_SRC, "reset source");
        rd(ADDR_MON_CTRL, "monitor");
        wr(8'h10, 8'hff);
        rd(8'h10, "unmapped");
        repeat (3)
        begin
            v = 8'($random(seed));
            wr(ADDR_POWER_MODE, v & 8'hfc);
            rd(ADDR_POWER_MODE, "flags");
        end
        $display("test registers done");
        wr(ADDR_POWER_MODE, mdl[ADDR_POWER_MODE] | 8'h01);
        @(negedge clk);
        chk(8'({ctrl.cpu_clk_en, ctrl.periph_clk_en, ctrl.timer3_en}), 8'h03, "nap enables");
        u_pmr_partner.fire(3, 1, 9'h020);
        wait_run(n);
        chk(8'(n), 8'h01, "nap exit");
        rd(ADDR_POWER_MODE, "nap readback");
        $display("test nap done");
        wr(ADDR_CLK_SEL, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($random(seed));
            timer3_ext_clk <= v[0];
            u_pmr_partner.fire(0, 1, 9'h008);
            wr(ADDR_OSC_CTRL, 8'h20);
            @(negedge clk);
            chk(8'({ctrl.int_osc_en, ctrl.periph_clk_en, ctrl.port_match_en, ctrl.timer3_en}), {7'h01, v[0]},
                "doze enables");
            u_pmr_partner.fire(1, 1, 9'h004);
            @(negedge clk);
            chk(8'(ctrl.cpu_clk_en), 8'h00, "pending ignored");
            u_pmr_partner.fire(2, 1, {4'h0, wk[i]});
            wait_run(n);
            chk(8'(n), 8'h06, "doze wake");
            rd(ADDR_POWER_MODE, "flags kept");
        end
        fork
            u_pmr_partner.fire(0, 6, 9'h010);
        join_none
        wr(ADDR_OSC_CTRL, 8'h20);
        wait_run(n);
        chk(8'(n), 8'h07, "held match wake");
        $display("test doze done");
        wr(ADDR_MON_CTRL, 8'h00);
        u_pmr_partner.fire(1, 3, 9'h080);
        @(negedge clk);
        chk(8'({ctrl.core_rst, rst_pin_oe_n}), 8'h03, "other reset pin");
        wait_run(n);
        mdl[ADDR_POWER_MODE] = 8'h00;
        mdl[ADDR_RST_SRC] = 8'h00;
        rd(ADDR_RST_SRC, "cause cleared");
        rd(ADDR_MON_CTRL, "monitor sticky");
        wr(ADDR_MON_CTRL, 8'h80);
        repeat (4) @(posedge clk);
        wr(ADDR_RST_SRC, 8'h02);
        u_pmr_partner.fire(1, 4, 9'h100);
        @(negedge clk);
        chk(8'({ctrl.core_rst, rst_pin_oe_n}), 8'h02, "supply reset pin");
        wait_run(n);
        chk(8'(n), 8'h01, "supply release");
        $display("test resets done");
        wr(ADDR_RST_SRC, 8'h04);
        wr(ADDR_POWER_MODE, 8'h02);
        repeat (8) @(negedge clk);
        chk(8'({ctrl.int_osc_en, ctrl.cpu_clk_en, ctrl.periph_clk_en, ctrl.core_rst}), 8'h00, "deep halt");
        u_pmr_partner.fire(0, 2, 9'h040);
        wait_run(n);
        mdl[ADDR_RST_SRC] = 8'h04;
        rd(ADDR_RST_SRC, "detector flag");
        rd(ADDR_POWER_MODE, "power mode reset");
        chk(8'(ctrl.clk_div), 8'(CLKDIV_RESET), "divider reset");
        wr(ADDR_POWER_MODE, 8'h02);
        u_pmr_partner.fire(2, 1, 9'h080);
        wait_run(n);
        chk(8'(n), 8'h02, "halt other reset");
        mdl[ADDR_RST_SRC] = 8'h00;
        rd(ADDR_RST_SRC, "flags cleared");
        $display("test halt done");
        give_verdict;
    end
endmodule
